// file: bench/e1_line_model.sv
// Line side model: sliced rails, recovered bit clock and level flags.
// Assumes the receiver samples the rails a few cycles after bit_clk rises.
module e1_line_model
  import e1_rx_maint_pkg::*;
(
  input wire logic clk_i, // Bench clock
  output line_in_t line_o // Line signals toward the receiver
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_neg = 1'b1;
  initial line_o = '0;
  // ==========================================================================
  // One bit of nine cycles; rails stand for the whole bit so the
  // synchroniser never sees them move near the taking edge
  task automatic send(input logic m, input logic v, input logic lo,
                      input logic hi);
    logic pol;
    pol = (m && !v) ? !last_neg : last_neg;
    @(posedge clk_i);
    line_o.pos <= m && !pol;
    line_o.neg <= m && pol;
    line_o.level_low <= lo;
    line_o.level_high <= hi;
    if (m) last_neg = pol;
    repeat (3) @(posedge clk_i);
    line_o.bit_clk <= 1'b1;
    repeat (3) @(posedge clk_i);
    line_o.bit_clk <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
endmodule

// file: bench/e1_rx_line_maintenance_ctrl_tb.sv
// Self-checking bench for the E1 receive maintenance block.
// Assumes the line model above and a short report second.
module e1_rx_line_maintenance_ctrl_tb;
  import e1_rx_maint_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC = 200;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [9:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] wdat = '0, rdat, got, seed = 32'h2142, r;
  logic ack, rx_data, rx_valid, los, exz, tx_ones, bpv;
  line_in_t line;
  afe_cfg_t afe;
  loop_t loops;
  logic [7:0] rm [256];
  logic [7:0] idxs [8] = '{8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C,
                           8'h31, 8'h30};
  int fails = 0, num_checks = 0, exz_n = 0, bpv_n = 0, rv_n = 0, n0, b0;
  int dq[$] = '{-1, -1, -1, -1};
  string pat = "1000VB00V101", dec = "100000000101";

  e1_rx_line_maintenance_ctrl #(.SECOND_CYCLES(SEC)) dut (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .line_i(line), .afe_cfg_o(afe), .loop_en_o(loops),
    .rx_data_o(rx_data), .rx_valid_o(rx_valid), .los_o(los), .exz_o(exz),
    .tx_all_ones_o(tx_ones), .bpv_insert_o(bpv));
  e1_line_model line_gen (.clk_i(clk_i), .line_o(line));

  initial begin
    forever #4 clk_i = !clk_i;
  end
  // ==========================================================================
  // Reference model and helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] msk(input logic [7:0] i);
    case (i)
      8'h27: return 8'h07;
      8'h28: return 8'h11;
      8'h29: return 8'h5F;
      8'h2A: return 8'h3F;
      8'h2B: return 8'h77;
      8'h2C: return 8'h07;
      8'h31: return 8'h5F;
      default: return 8'h00;
    endcase
  endfunction
  function automatic afe_cfg_t afe_model();
    afe_cfg_t a;
    logic [4:0] q;
    q = rm[8'h29][4:0];
    a.depth_bits = rm[8'h27][2] ? 8'h20 :
                   (rm[8'h27][1] ? 8'h40 : 8'h80);
    a.corner_sel = rm[8'h27][0];
    a.power_down = rm[8'h28][4];
    a.ami_sel = rm[8'h28][0];
    a.equalizer_enable = rm[8'h29][6];
    a.los_q_db = !a.equalizer_enable ? 6'h00 : (q >= 5'h16 ? 6'h30 : 6'h04 + {q, 1'b0});
    a.slice_pct = 7'h28 + 7'h0A * rm[8'h2A][5:4];
    a.peak_bits = 9'h020 << rm[8'h2A][3:2];
    a.mon_gain_db = (rm[8'h2A][1:0] == 2'h1) ? 5'h16 : 5'h00;
    return a;
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    num_checks++;
    if (seen !== want) begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    sel <= s;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    got = rdat;
    if (n >= 40) fails++;
    if (w && s[0]) rm[i] = d & msk(i);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    bus(1'b1, i, d, 4'hF);
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] want);
    bus(1'b0, i, 8'h00, 4'hF);
    check(got, want);
  endtask
  // Expectation is queued before the bit goes out: its strobe comes mid-bit
  task automatic bitx(input logic m, input logic v, input logic lo, int e);
    dq.push_back(e);
    line_gen.send(m, v, lo, !lo);
  endtask
  task automatic zeros(input int n);
    repeat (n) bitx(1'b0, 1'b0, 1'b0, 0);
    bitx(1'b1, 1'b0, 1'b0, 1);
  endtask
  task automatic complete_run();
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Output monitors
  always @(posedge clk_i) begin
    if (exz === 1'b1) exz_n++;
    if (bpv === 1'b1) bpv_n++;
    if (rx_valid === 1'b1) rv_n++;
    if (rx_valid === 1'b1 && dq.size() > 0) begin
      if (dq[0] >= 0) check(rx_data, dq[0][0]);
      void'(dq.pop_front());
    end
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    fails++;
    complete_run();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    foreach (rm[i]) rm[i] = 8'h00;
    rm[8'h29] = 8'h15;
    rm[8'h2A] = 8'h18;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (idxs[i]) rd(idxs[i], {24'h0, rm[idxs[i]]});
    check(afe, afe_model());
    repeat (48) begin
      r = rnd();
      wr(idxs[r[10:8]], r[7:0]);
      check(afe, afe_model());
      check(loops, {rm[8'h2B][6:4], rm[8'h2B][2:0]});
      rd(idxs[r[10:8]], {24'h0, rm[idxs[r[10:8]]]});
    end
    bus(1'b1, 8'h2B, 8'hFF, 4'hE);
    rd(8'h2B, {24'h0, rm[8'h2B]});
    wr(8'h28, 8'h00);
    wr(8'h2C, 8'h00);
    wr(8'h31, 8'h00);
    foreach (pat[i]) bitx(pat[i] != "0", pat[i] == "V", 1'b0,
      dec[i] == "1");
    wr(8'h28, 8'h01);
    repeat (24) begin
      r = rnd();
      bitx(r[0], 1'b0, 1'b0, r[0]);
    end
    // A mark ends any random zero run before the run-length tests
    bitx(1'b1, 1'b0, 1'b0, 1);
    // Two marks keep the model's polarity in step with the receiver
    wr(8'h28, 8'h11);
    n0 = rv_n;
    repeat (2) line_gen.send(1'b1, 1'b0, 1'b0, 1'b1);
    check(rv_n - n0, 0);
    wr(8'h28, 8'h01);
    b0 = bpv_n;
    wr(8'h31, 8'h40);
    wr(8'h31, 8'h40);
    wr(8'h31, 8'h00);
    wr(8'h31, 8'h44);
    check(bpv_n - b0, 2);
    wr(8'h31, 8'h05);
    wr(8'h31, 8'h04);
    n0 = exz_n;
    zeros(15);
    zeros(16);
    check(exz_n - n0, 1);
    wr(8'h28, 8'h00);
    zeros(3);
    zeros(9);
    check(exz_n - n0, 2);
    wr(8'h31, 8'h14);
    zeros(4);
    wr(8'h28, 8'h01);
    zeros(80);
    zeros(81);
    check(exz_n - n0, 4);
    wr(8'h31, 8'h15);
    rd(8'h40, 32'h4);
    rd(8'h41, 32'h0);
    wr(8'h31, 8'h00);
    zeros(16);
    check(exz_n - n0, 5);
    wr(8'h31, 8'h01);
    rd(8'h40, 32'h0);
    wr(8'h31, 8'h06);
    zeros(16);
    n0 = 0;
    do begin
      bus(1'b0, 8'h40, 8'h00, 4'hF);
      n0++;
    end while (got === 32'h0 && n0 < 150);
    check(got, 32'h1);
    wr(8'h31, 8'h00);
    wr(8'h28, 8'h00);
    wr(8'h2C, 8'h03);
    repeat (31) bitx(1'b0, 1'b0, 1'b1, -1);
    check(los, 1'b0);
    bitx(1'b0, 1'b0, 1'b1, -1);
    check({los, tx_ones}, 2'b11);
    rd(8'h36, 32'h1);
    repeat (8) bitx(1'b0, 1'b0, 1'b1, 1);
    repeat (64) bitx(1'b0, 1'b0, 1'b0, -1);
    check(los, 1'b1);
    repeat (64) bitx(1'b1, 1'b0, 1'b0, -1);
    check({los, tx_ones}, 2'b00);
    wr(8'h2C, 8'h04);
    repeat (2047) bitx(1'b0, 1'b0, 1'b1, -1);
    check(los, 1'b0);
    bitx(1'b0, 1'b0, 1'b1, -1);
    check({los, tx_ones}, 2'b10);
    repeat (64) bitx(1'b1, 1'b0, 1'b0, -1);
    check(los, 1'b0);
    complete_run();
  end
endmodule

// file: design/e1_rx_line_maintenance_ctrl.sv
// E1 receive line maintenance control for one channel: register bank,
// line decoder, loss-of-signal and zero-run monitors, error counter.
// Assumes a classic Wishbone master and unsynchronised line inputs.
module e1_rx_line_maintenance_ctrl
  import e1_rx_maint_pkg::*;
#(
  parameter int SECOND_CYCLES = CYCLES_PER_SECOND // Cycles per report second
) (
  input wire logic clk_i, // 125 MHz clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [9:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lane selects
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire line_in_t line_i, // Rails, bit clock and level flags
  output afe_cfg_t afe_cfg_o, // Analog front end settings
  output loop_t loop_en_o, // Loopback enables
  output logic rx_data_o, // Decoded receive bit
  output logic rx_valid_o, // Strobe per decoded bit
  output logic los_o, // Loss of signal
  output logic exz_o, // Pulse per zero-run error
  output logic tx_all_ones_o, // Force ones on transmit
  output logic bpv_insert_o // Pulse: insert one violation
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [7:0] jitter;
    logic [7:0] rx_a;
    logic [7:0] rx_b;
    logic [7:0] rx_c;
    logic [7:0] loop;
    logic [7:0] los_ctl;
    logic [7:0] err_ctl;
  } regs_t;

  typedef struct packed {
    regs_t regs;
    logic ack;
    logic [7:0] rdat;
    line_in_t sync1;
    line_in_t sync2;
    logic bit_clk_d;
    logic seen;
    logic last_neg;
    logic [3:0] pipe;
    logic [11:0] below_cnt;
    logic los;
    logic [4:0] win_cnt;
    logic [5:0] mark_cnt;
    logic [4:0] zrun;
    logic [4:0] zmax;
    logic high_all;
    logic [6:0] exz_run;
    logic exz;
    logic [15:0] err_cnt;
    logic [15:0] cnt_rpt;
    logic [26:0] sec_cnt;
    logic bpv;
    afe_cfg_t afe;
    logic rx_data;
    logic rx_valid;
    logic tx_ones;
  } state_t;

  state_t st;
  state_t next_st;
  logic [7:0] idx;
  logic [7:0] wdat;
  logic wr_hit;
  logic tick;
  logic mark;
  logic viol;
  logic manual_rise;
  logic sec_end;
  logic xfer;
  logic counting;
  logic [4:0] thr;
  logic [6:0] exz_limit;
  logic [6:0] run_new;
  logic [11:0] los_limit;
  logic [11:0] below_new;
  logic [5:0] marks_new;
  logic [4:0] zrun_new;
  logic [4:0] zmax_new;
  logic high_new;

  function automatic logic rising(input logic was, input logic now);
    rising = !was && now;
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    next_st = st;
    idx = wb_adr_i[9:2];
    wdat = wb_dat_i[7:0];
    wr_hit = wb_cyc_i && wb_stb_i && !st.ack && wb_we_i && wb_sel_i[0];
    below_new = st.below_cnt;
    marks_new = st.mark_cnt;
    zrun_new = st.zrun;
    zmax_new = st.zmax;
    high_new = st.high_all;
    run_new = st.exz_run;

    // Bus slave: every access, mapped or not, is answered one cycle later
    next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;
    if (next_st.ack) begin
      case (idx)
        IDX_JITTER: next_st.rdat = st.regs.jitter;
        IDX_RX_A: next_st.rdat = st.regs.rx_a;
        IDX_RX_B: next_st.rdat = st.regs.rx_b;
        IDX_RX_C: next_st.rdat = st.regs.rx_c;
        IDX_LOOP: next_st.rdat = st.regs.loop;
        IDX_LOS_CTL: next_st.rdat = st.regs.los_ctl;
        IDX_ERR_CTL: next_st.rdat = st.regs.err_ctl;
        IDX_LINE_STATUS: next_st.rdat = 8'(st.los) << B_LOS_S;
        IDX_CNT_LO: next_st.rdat = st.cnt_rpt[7:0];
        IDX_CNT_HI: next_st.rdat = st.cnt_rpt[15:8];
        default: next_st.rdat = 8'h00;
      endcase
    end
    if (wr_hit) begin
      case (idx)
        IDX_JITTER: next_st.regs.jitter = wdat & MASK_JITTER;
        IDX_RX_A: next_st.regs.rx_a = wdat & MASK_RX_A;
        IDX_RX_B: next_st.regs.rx_b = wdat & MASK_RX_B;
        IDX_RX_C: next_st.regs.rx_c = wdat & MASK_RX_C;
        IDX_LOOP: next_st.regs.loop = wdat & MASK_LOOP;
        IDX_LOS_CTL: next_st.regs.los_ctl = wdat & MASK_LOS_CTL;
        IDX_ERR_CTL: next_st.regs.err_ctl = wdat & MASK_ERR_CTL;
        default: next_st.regs = st.regs;
      endcase
    end

    // Only a fresh 0-to-1 write fires; holding the bit at 1 does nothing
    next_st.bpv = rising(st.regs.err_ctl[B_BPV],
                         next_st.regs.err_ctl[B_BPV]);
    manual_rise = !st.regs.err_ctl[B_AUTO] &&
                  rising(st.regs.err_ctl[B_XFER],
                         next_st.regs.err_ctl[B_XFER]);

    // ========================================================================
    // Line sampling: two flops, then edge of the bit clock
    next_st.sync1 = line_i;
    next_st.sync2 = st.sync1;
    next_st.bit_clk_d = st.sync2.bit_clk;
    // A powered-down receive path takes no bits at all
    tick = st.sync2.bit_clk && !st.bit_clk_d &&
           !st.regs.rx_a[B_RX_OFF];
    mark = st.sync2.pos || st.sync2.neg;
    viol = mark && st.seen && (st.sync2.neg == st.last_neg);
    los_limit = st.regs.los_ctl[B_CRIT] ? LOS_LONG_BITS
                                       : LOS_SHORT_BITS;
    if (!st.regs.rx_a[B_DECODER]) begin
      exz_limit = EXZ_HDB3;
    end else if (st.regs.err_ctl[B_ZRUN_CRIT]) begin
      exz_limit = EXZ_AMI_LONG;
    end else begin
      exz_limit = EXZ_AMI_SHORT;
    end

    next_st.rx_valid = 1'b0;
    next_st.exz = 1'b0;
    if (tick) begin
      // Both decoders share a four-bit delay so latency never changes
      next_st.rx_valid = 1'b1;
      next_st.rx_data = (st.regs.los_ctl[B_RAISE] && st.los) ||
                        st.pipe[3];
      next_st.pipe = {st.pipe[2:0], mark};
      if (!st.regs.rx_a[B_DECODER] && viol) begin
        next_st.pipe = 4'h0;
      end
      if (mark) begin
        next_st.last_neg = st.sync2.neg;
        next_st.seen = 1'b1;
      end

      // Clearing window of 32 bit periods
      marks_new = st.mark_cnt + {5'h00, mark};
      zrun_new = mark ? 5'h00 :
                 (st.zrun == 5'h1F) ? st.zrun : st.zrun + 5'h01;
      zmax_new = (zrun_new > st.zmax) ? zrun_new : st.zmax;
      high_new = st.high_all && st.sync2.level_high;
      next_st.win_cnt = st.win_cnt + 5'h01;
      next_st.mark_cnt = marks_new;
      next_st.zrun = zrun_new;
      next_st.zmax = zmax_new;
      next_st.high_all = high_new;
      if (st.win_cnt == WINDOW_LAST) begin
        if (high_new && marks_new >= MIN_MARKS &&
            zmax_new < ZERO_RUN_MAX) begin
          next_st.los = 1'b0;
        end
        next_st.mark_cnt = 6'h00;
        next_st.zrun = 5'h00;
        next_st.zmax = 5'h00;
        next_st.high_all = 1'b1;
      end

      // Declaring wins over clearing when both land on one bit
      below_new = !st.sync2.level_low ? 12'h000 :
                  (st.below_cnt == 12'hFFF) ? st.below_cnt :
                  st.below_cnt + 12'h001;
      next_st.below_cnt = below_new;
      if (below_new == los_limit) begin
        next_st.los = 1'b1;
      end

      // Zero runs are judged on the raw line, before substitution removal
      run_new = mark ? 7'h00 :
                (st.exz_run == 7'h7F) ? st.exz_run : st.exz_run + 7'h01;
      next_st.exz_run = run_new;
      next_st.exz = (run_new == exz_limit + 7'h01);
    end

    // ========================================================================
    // Error counter and report
    counting = st.exz &&
               (st.regs.err_ctl[B_CNT_SEL +: 2] == CNT_SEL_ON);
    sec_end = (st.sec_cnt == 27'(SECOND_CYCLES - 1));
    next_st.sec_cnt = sec_end ? 27'h0000000 : st.sec_cnt + 27'h0000001;
    xfer = manual_rise || (st.regs.err_ctl[B_AUTO] && sec_end);
    if (xfer) begin
      // Counter restarts after each report; a coincident event is kept
      next_st.cnt_rpt = st.err_cnt;
      next_st.err_cnt = {15'h0000, counting};
    end else if (counting && st.err_cnt != 16'hFFFF) begin
      next_st.err_cnt = st.err_cnt + 16'h0001;
    end

    // ========================================================================
    // Front end settings
    case (st.regs.jitter[B_DEPTH +: 2])
      2'h0: next_st.afe.depth_bits = DEPTH_128;
      2'h1: next_st.afe.depth_bits = DEPTH_64;
      default: next_st.afe.depth_bits = DEPTH_32;
    endcase
    next_st.afe.corner_sel = st.regs.jitter[B_CORNER];
    next_st.afe.power_down = st.regs.rx_a[B_RX_OFF];
    next_st.afe.ami_sel = st.regs.rx_a[B_DECODER];
    next_st.afe.equalizer_enable = st.regs.rx_b[B_EQ];
    thr = st.regs.rx_b[B_THR +: 5];
    if (!st.regs.rx_b[B_EQ]) begin
      next_st.afe.los_q_db = 6'h00;
    end else if (thr >= Q_LAST_CODE) begin
      next_st.afe.los_q_db = Q_MAX_DB;
    end else begin
      next_st.afe.los_q_db = Q_BASE_DB + {thr, 1'b0};
    end
    next_st.afe.slice_pct = SLICE_BASE_PCT + SLICE_STEP_PCT *
                            {5'h00, st.regs.rx_c[B_SLICE +: 2]};
    next_st.afe.peak_bits = PEAK_BASE_BITS <<
                            st.regs.rx_c[B_PEAK +: 2];
    // Reserved gain codes fall back to 0 dB
    next_st.afe.mon_gain_db =
      (st.regs.rx_c[B_GAIN +: 2] == MON_GAIN_HIGH_CODE) ?
      MON_GAIN_HIGH_DB : 5'h00;
    next_st.tx_ones = st.regs.los_ctl[B_TX_ONES] && st.los;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.regs.jitter <= RST_JITTER;
      st.regs.rx_a <= RST_RX_A;
      st.regs.rx_b <= RST_RX_B;
      st.regs.rx_c <= RST_RX_C;
      st.regs.loop <= RST_LOOP;
      st.regs.los_ctl <= RST_LOS_CTL;
      st.regs.err_ctl <= RST_ERR_CTL;
      st.high_all <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign wb_dat_o = {24'h000000, st.rdat};
  assign wb_ack_o = st.ack;
  assign afe_cfg_o = st.afe;
  assign loop_en_o = {st.regs.loop[B_LOOP_HI +: 3],
                      st.regs.loop[B_LOOP_LO +: 3]};
  assign rx_data_o = st.rx_data;
  assign rx_valid_o = st.rx_valid;
  assign los_o = st.los;
  assign exz_o = st.exz;
  assign tx_all_ones_o = st.tx_ones;
  assign bpv_insert_o = st.bpv;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_depth_decode: assert property (
    $past(st.regs.jitter[B_DEPTH +: 2]) == 2'h1 |->
      afe_cfg_o.depth_bits == DEPTH_64)
    else $error("jitter depth code 01 not shown as 64 bits");

  a_power_down: assert property (
    st.regs.rx_a[B_RX_OFF] && $past(st.regs.rx_a[B_RX_OFF]) |=>
      !rx_valid_o)
    else $error("receive bit taken while powered down");

  a_loop_map: assert property (
    wr_hit && idx == IDX_LOOP |=>
      loop_en_o.dig_one == $past(wdat[6]) &&
      loop_en_o.dig_two == $past(wdat[0]))
    else $error("loopback enables do not follow the write");

  a_los_short: assert property (
    $rose(st.los) && !$past(st.regs.los_ctl[B_CRIT]) |->
      st.below_cnt == LOS_SHORT_BITS)
    else $error("loss declared without 32 low bit intervals");

  a_los_long: assert property (
    $rose(st.los) && $past(st.regs.los_ctl[B_CRIT]) |->
      st.below_cnt == LOS_LONG_BITS)
    else $error("loss declared without 2048 low bit intervals");

  a_los_clear: assert property (
    $fell(st.los) |-> st.win_cnt == 5'h00 && $past(st.sync2.level_high))
    else $error("loss cleared outside a good window end");

  a_rx_ones: assert property (
    st.rx_valid && $past(st.los && st.regs.los_ctl[B_RAISE]) |->
      rx_data_o)
    else $error("receive data not forced to one during loss");

  a_tx_ones: assert property (
    st.los && st.regs.los_ctl[B_TX_ONES] |=> tx_all_ones_o ##1 1'b1)
    else $error("transmit ones not asserted during loss");

  a_bpv_edge: assert property (
    bpv_insert_o |-> !$past(st.regs.err_ctl[B_BPV]) &&
      st.regs.err_ctl[B_BPV] ##1 !bpv_insert_o)
    else $error("violation request not a single pulse on a rising write");

  a_zero_limit: assert property (
    exz_o |-> st.exz_run == $past(exz_limit) + 7'h01)
    else $error("zero-run error at the wrong run length");

  a_count_step: assert property (
    counting && !xfer && st.err_cnt != 16'hFFFF |=>
      st.err_cnt == $past(st.err_cnt) + 16'h0001)
    else $error("counted zero-run error not added");

  a_count_hold: assert property (
    !counting && !xfer |=> $stable(st.err_cnt))
    else $error("error counter moved without a counted event");

  a_auto_report: assert property (
    st.regs.err_ctl[B_AUTO] && sec_end |=>
      st.cnt_rpt == $past(st.err_cnt))
    else $error("automatic report missed at the second boundary");

  a_manual_report: assert property (
    manual_rise |=> st.cnt_rpt == $past(st.err_cnt) ##1 1'b1)
    else $error("manual report not copied on the transfer edge");

  a_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held for more than one cycle");

endmodule

// file: design/e1_rx_maint_pkg.sv
// Constants, field layout and carrier types for the E1 receive line
// maintenance block; assumes a 125 MHz clock and a 32-bit Wishbone bus.
package e1_rx_maint_pkg;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int ONE_SECOND_NS = 1_000_000_000;
  localparam int CYCLES_PER_SECOND = ONE_SECOND_NS / CLK_PERIOD_NS;
  // ==========================================================================
  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_JITTER = 8'h27, IDX_RX_A = 8'h28;
  localparam logic [7:0] IDX_RX_B = 8'h29, IDX_RX_C = 8'h2A;
  localparam logic [7:0] IDX_LOOP = 8'h2B, IDX_LOS_CTL = 8'h2C;
  localparam logic [7:0] IDX_ERR_CTL = 8'h31, IDX_LINE_STATUS = 8'h36;
  localparam logic [7:0] IDX_CNT_LO = 8'h40, IDX_CNT_HI = 8'h41;
  // Reset values and writable bits
  localparam logic [7:0] RST_JITTER = 8'h00, RST_RX_A = 8'h00;
  localparam logic [7:0] RST_RX_B = 8'h15, RST_RX_C = 8'h18;
  localparam logic [7:0] RST_LOOP = 8'h00, RST_LOS_CTL = 8'h00;
  localparam logic [7:0] RST_ERR_CTL = 8'h00;
  localparam logic [7:0] MASK_JITTER = 8'h07, MASK_RX_A = 8'h11;
  localparam logic [7:0] MASK_RX_B = 8'h5F, MASK_RX_C = 8'h3F;
  localparam logic [7:0] MASK_LOOP = 8'h77, MASK_LOS_CTL = 8'h07;
  localparam logic [7:0] MASK_ERR_CTL = 8'h5F;
  // ==========================================================================
  // Field positions
  localparam int B_CORNER = 0, B_DEPTH = 1, B_DECODER = 0, B_RX_OFF = 4;
  localparam int B_THR = 0, B_EQ = 6, B_GAIN = 0, B_PEAK = 2, B_SLICE = 4;
  localparam int B_LOOP_LO = 0, B_LOOP_HI = 4;
  localparam int B_TX_ONES = 0, B_RAISE = 1, B_CRIT = 2, B_LOS_S = 0;
  localparam int B_XFER = 0, B_AUTO = 1, B_CNT_SEL = 2;
  localparam int B_ZRUN_CRIT = 4, B_BPV = 6;
  // ==========================================================================
  // Line monitor figures, counted in bit intervals
  localparam logic [11:0] LOS_SHORT_BITS = 12'h020, LOS_LONG_BITS = 12'h800;
  localparam logic [4:0] WINDOW_LAST = 5'h1F, ZERO_RUN_MAX = 5'h10;
  localparam logic [5:0] MIN_MARKS = 6'h04;
  localparam logic [6:0] EXZ_AMI_SHORT = 7'h0F, EXZ_AMI_LONG = 7'h50;
  localparam logic [6:0] EXZ_HDB3 = 7'h03;
  localparam logic [1:0] CNT_SEL_ON = 2'h1;
  // Front end setting values
  localparam logic [7:0] DEPTH_128 = 8'h80, DEPTH_64 = 8'h40, DEPTH_32 = 8'h20;
  localparam logic [5:0] Q_BASE_DB = 6'h04, Q_MAX_DB = 6'h30;
  localparam logic [4:0] Q_LAST_CODE = 5'h16;
  localparam logic [6:0] SLICE_BASE_PCT = 7'h28, SLICE_STEP_PCT = 7'h0A;
  localparam logic [8:0] PEAK_BASE_BITS = 9'h020;
  localparam logic [4:0] MON_GAIN_HIGH_DB = 5'h16;
  localparam logic [1:0] MON_GAIN_HIGH_CODE = 2'h1;
  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic level_high;
    logic level_low;
    logic bit_clk;
    logic neg;
    logic pos;
  } line_in_t;
  typedef struct packed {
    logic dig_one;
    logic sys_local;
    logic sys_remote;
    logic remote;
    logic analog;
    logic dig_two;
  } loop_t;
  typedef struct packed {
    logic [7:0] depth_bits;
    logic corner_sel;
    logic power_down;
    logic ami_sel;
    logic equalizer_enable;
    logic [5:0] los_q_db;
    logic [6:0] slice_pct;
    logic [8:0] peak_bits;
    logic [4:0] mon_gain_db;
  } afe_cfg_t;
endpackage
